/* ext_irq_pkg.sv */
// Purpose: shared constants and carriers for the external pin interrupt block
// Assumes: axi4-lite register access, 32-bit data, one word per register
// Notes:   offsets are byte addresses of aligned words
package ext_irq_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // register byte offsets
  localparam logic [5:0] off_sense  = 6'h00;  // ext_sense_control
  localparam logic [5:0] off_mask   = 6'h04;  // ext_request_mask
  localparam logic [5:0] off_flags  = 6'h08;  // ext_request_flags
  localparam logic [5:0] off_genab  = 6'h0c;  // change_group_enable
  localparam logic [5:0] off_gflag  = 6'h10;  // change_group_flags
  localparam logic [5:0] off_msk3   = 6'h14;  // change_mask_group3
  localparam logic [5:0] off_msk2   = 6'h18;  // change_mask_group2
  localparam logic [5:0] off_msk1   = 6'h1c;  // group 1 mask
  localparam logic [5:0] off_msk0   = 6'h20;  // group 0 mask
  localparam logic [5:0] off_ctrl   = 6'h24;  // global enable (bit 0)
  localparam logic [5:0] off_ack    = 6'h28;  // vector entry acknowledge, write only

  ////////////////////////////////////////////////////////////////////////////
  // field layout and reset values
  localparam int          n_ext      = 4;      // dedicated pins
  localparam int          n_chg      = 27;     // change inputs
  localparam int          n_grp      = 4;      // change groups
  localparam logic [7:0]  rst_byte   = 8'h00;  // every register resets to zero
  localparam logic [2:0]  msk3_used  = 3'h7;   // group 3 mask bits 2..0
  localparam logic [1:0]  resp_okay  = 2'h0;   // axi okay
  localparam logic [1:0]  resp_slverr = 2'h2;  // axi slave error for unmapped

  // sense field codes
  localparam logic [1:0]  sense_low  = 2'h0;
  localparam logic [1:0]  sense_any  = 2'h1;
  localparam logic [1:0]  sense_fall = 2'h2;
  localparam logic [1:0]  sense_rise = 2'h3;

  ////////////////////////////////////////////////////////////////////////////
  // state carriers
  typedef enum logic [0:0] {bus_idle, bus_resp} bus_state_e;

  typedef struct packed {
    logic [7:0]  sense;      // ext_sense_control
    logic [3:0]  mask;       // ext_request_mask
    logic [3:0]  flags;      // ext_request_flags
    logic [3:0]  genab;      // change_group_enable
    logic [3:0]  gflag;      // change_group_flags
    logic [2:0]  msk3;       // change_mask_group3
    logic [7:0]  msk2;       // change_mask_group2
    logic [7:0]  msk1;       // group 1 mask
    logic [7:0]  msk0;       // group 0 mask
    logic        gie;        // global enable
    logic [3:0]  ext_s1;     // dedicated pin sync stage 1
    logic [3:0]  ext_s2;     // dedicated pin sync stage 2
    logic [3:0]  ext_old;    // previous synced sample
    logic [26:0] chg_s1;     // change input sync stage 1
    logic [26:0] chg_s2;     // change input sync stage 2
    logic [26:0] chg_old;    // previous synced sample
    bus_state_e  wst;        // write channel state
    logic [1:0]  bresp;      // write response code
    bus_state_e  rst_st;     // read channel state
    logic [31:0] rdata;      // read data
    logic [1:0]  rresp;      // read response code
  } irq_state_s;

endpackage

/* ext_pin_irq.sv */
// Purpose: external pin and pin-change interrupt logic with axi4-lite registers
// Assumes: pins synchronous enough for a two-flop synchroniser; one clock
// Notes:   vector acknowledge arrives as a write to the ack register or on i_ext_vec_ack / i_grp_vec_ack
`timescale 1ns/100ps

module ext_pin_irq (
  input  wire logic        i_sys_clk,     // 50 mhz system clock
  input  wire logic        i_rst_n,       // async reset, active low
  input  wire logic [3:0]  i_ext_irq_pins, // dedicated request pins
  input  wire logic [26:0] i_change_inputs, // pin-change inputs
  input  wire logic [3:0]  i_ext_vec_ack, // dedicated vector entered, pulse
  input  wire logic [3:0]  i_grp_vec_ack, // group vector entered, pulse
  output logic      [3:0]  o_ext_req,     // dedicated vector requests
  output logic      [3:0]  o_grp_req,     // group vector requests
  output logic             o_wake,        // clockless wake level
  input  wire logic [5:0]  s_axi_awaddr,  // write address
  input  wire logic        s_axi_awvalid, // write address valid
  output logic             s_axi_awready, // write address ready
  input  wire logic [31:0] s_axi_wdata,   // write data
  input  wire logic [3:0]  s_axi_wstrb,   // write strobes
  input  wire logic        s_axi_wvalid,  // write data valid
  output logic             s_axi_wready,  // write data ready
  output logic [1:0]       s_axi_bresp,   // write response
  output logic             s_axi_bvalid,  // write response valid
  input  wire logic        s_axi_bready,  // write response ready
  input  wire logic [5:0]  s_axi_araddr,  // read address
  input  wire logic        s_axi_arvalid, // read address valid
  output logic             s_axi_arready, // read address ready
  output logic [31:0]      s_axi_rdata,   // read data
  output logic [1:0]       s_axi_rresp,   // read response
  output logic             s_axi_rvalid,  // read data valid
  input  wire logic        s_axi_rready   // read data ready
);

  ////////////////////////////////////////////////////////////////////////////
  // helpers

  // true when the offset is a mapped register
  function automatic logic is_mapped(input logic [5:0] a);
    is_mapped = (a == ext_irq_pkg::off_sense) || (a == ext_irq_pkg::off_mask) ||
                (a == ext_irq_pkg::off_flags) || (a == ext_irq_pkg::off_genab) ||
                (a == ext_irq_pkg::off_gflag) || (a == ext_irq_pkg::off_msk3) ||
                (a == ext_irq_pkg::off_msk2) || (a == ext_irq_pkg::off_msk1) ||
                (a == ext_irq_pkg::off_msk0) || (a == ext_irq_pkg::off_ctrl) ||
                (a == ext_irq_pkg::off_ack);
  endfunction

  // sense field of pin n
  function automatic logic [1:0] sense_of(input logic [7:0] s, input int n);
    sense_of = s[2*n +: 2];
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // state
  ext_irq_pkg::irq_state_s st;       // registered state
  ext_irq_pkg::irq_state_s next_st;  // next state

  logic        wr_go;       // write address and data both present
  logic [3:0]  ext_hit;     // dedicated edge or change events
  logic [3:0]  low_lvl;     // dedicated pins low and in level mode
  logic [3:0]  grp_hit;     // group change events
  logic [26:0] chg_en;      // per-input enables
  logic [26:0] chg_diff;    // synced change per input
  logic [3:0]  wclr_ext;    // write-one clears of pin flags
  logic [3:0]  wclr_grp;    // write-one clears of group flags
  logic [3:0]  ack_ext;     // vector entry for pins
  logic [3:0]  ack_grp;     // vector entry for groups
  logic        wr_byte0;    // low byte lane written
  logic [31:0] rd_word;     // selected read word

  ////////////////////////////////////////////////////////////////////////////
  // event detection from synchronised samples
  always_comb
  begin
    wr_go    = (st.wst == ext_irq_pkg::bus_idle) && s_axi_awvalid && s_axi_wvalid;
    wr_byte0 = wr_go && s_axi_wstrb[0];
    // per-input enables from group masks and group enables
    chg_en   = {st.msk3 & {3{st.genab[3]}}, st.msk2 & {8{st.genab[2]}},
                st.msk1 & {8{st.genab[1]}}, st.msk0 & {8{st.genab[0]}}};
    chg_diff = st.chg_s2 ^ st.chg_old;
    for (int g = 0; g < 3; g++)
    begin
      grp_hit[g] = |(chg_diff[8*g +: 8] & chg_en[8*g +: 8]);
    end
    grp_hit[3] = |(chg_diff[26:24] & chg_en[26:24]);
    for (int n = 0; n < ext_irq_pkg::n_ext; n++)
    begin
      // pins are read as inputs even when driven by the device itself
      case (sense_of(st.sense, n))
        ext_irq_pkg::sense_low:  ext_hit[n] = 1'b0;
        ext_irq_pkg::sense_any:  ext_hit[n] = st.ext_s2[n] ^ st.ext_old[n];
        ext_irq_pkg::sense_fall: ext_hit[n] = st.ext_old[n] & ~st.ext_s2[n];
        ext_irq_pkg::sense_rise: ext_hit[n] = ~st.ext_old[n] & st.ext_s2[n];
        default:                 ext_hit[n] = 1'b0;
      endcase
      // level request straight from the pin, no clock needed
      low_lvl[n] = (sense_of(st.sense, n) == ext_irq_pkg::sense_low) &&
                   !i_ext_irq_pins[n];
    end
    wclr_ext = (wr_byte0 && s_axi_awaddr == ext_irq_pkg::off_flags) ? s_axi_wdata[3:0] : 4'h0;
    wclr_grp = (wr_byte0 && s_axi_awaddr == ext_irq_pkg::off_gflag) ? s_axi_wdata[3:0] : 4'h0;
    ack_ext  = i_ext_vec_ack |
               ((wr_byte0 && s_axi_awaddr == ext_irq_pkg::off_ack) ? s_axi_wdata[3:0] : 4'h0);
    ack_grp  = i_grp_vec_ack |
               ((wr_byte0 && s_axi_awaddr == ext_irq_pkg::off_ack) ? s_axi_wdata[7:4] : 4'h0);
  end

  ////////////////////////////////////////////////////////////////////////////
  // read word select, unused bits zero
  always_comb
  begin
    rd_word = 32'h0;
    case (s_axi_araddr)
      ext_irq_pkg::off_sense: rd_word = {24'h0, st.sense};
      ext_irq_pkg::off_mask:  rd_word = {28'h0, st.mask};
      ext_irq_pkg::off_flags: rd_word = {28'h0, st.flags};
      ext_irq_pkg::off_genab: rd_word = {28'h0, st.genab};
      ext_irq_pkg::off_gflag: rd_word = {28'h0, st.gflag};
      ext_irq_pkg::off_msk3:  rd_word = {29'h0, st.msk3};
      ext_irq_pkg::off_msk2:  rd_word = {24'h0, st.msk2};
      ext_irq_pkg::off_msk1:  rd_word = {24'h0, st.msk1};
      ext_irq_pkg::off_msk0:  rd_word = {24'h0, st.msk0};
      ext_irq_pkg::off_ctrl:  rd_word = {31'h0, st.gie};
      default:                rd_word = 32'h0;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // next state
  always_comb
  begin
    next_st = st;
    // two-flop synchronisers, stage 1 only feeds stage 2
    next_st.ext_s1  = i_ext_irq_pins;
    next_st.ext_s2  = st.ext_s1;
    next_st.ext_old = st.ext_s2;
    next_st.chg_s1  = i_change_inputs;
    next_st.chg_s2  = st.chg_s1;
    next_st.chg_old = st.chg_s2;
    // register writes
    if (wr_byte0)
    begin
      case (s_axi_awaddr)
        ext_irq_pkg::off_sense: next_st.sense = s_axi_wdata[7:0];
        ext_irq_pkg::off_mask:  next_st.mask  = s_axi_wdata[3:0];
        ext_irq_pkg::off_genab: next_st.genab = s_axi_wdata[3:0];
        ext_irq_pkg::off_msk3:  next_st.msk3  = s_axi_wdata[2:0] & ext_irq_pkg::msk3_used;
        ext_irq_pkg::off_msk2:  next_st.msk2  = s_axi_wdata[7:0];
        ext_irq_pkg::off_msk1:  next_st.msk1  = s_axi_wdata[7:0];
        ext_irq_pkg::off_msk0:  next_st.msk0  = s_axi_wdata[7:0];
        ext_irq_pkg::off_ctrl:  next_st.gie   = s_axi_wdata[0];
        default:                next_st.gie   = st.gie;
      endcase
    end
    // flags: set wins over clear
    next_st.flags = (st.flags & ~wclr_ext & ~ack_ext) | ext_hit;
    for (int n = 0; n < ext_irq_pkg::n_ext; n++)
    begin
      if (sense_of(st.sense, n) == ext_irq_pkg::sense_low)
      begin
        next_st.flags[n] = 1'b0;
      end
    end
    next_st.gflag = (st.gflag & ~wclr_grp & ~ack_grp) | grp_hit;
    // write channel
    case (st.wst)
      ext_irq_pkg::bus_idle:
      begin
        if (wr_go)
        begin
          next_st.wst   = ext_irq_pkg::bus_resp;
          next_st.bresp = is_mapped(s_axi_awaddr) ? ext_irq_pkg::resp_okay : ext_irq_pkg::resp_slverr;
        end
      end
      ext_irq_pkg::bus_resp:
      begin
        if (s_axi_bready)
        begin
          next_st.wst = ext_irq_pkg::bus_idle;
        end
      end
      default: next_st.wst = ext_irq_pkg::bus_idle;
    endcase
    // read channel
    case (st.rst_st)
      ext_irq_pkg::bus_idle:
      begin
        if (s_axi_arvalid)
        begin
          next_st.rst_st = ext_irq_pkg::bus_resp;
          next_st.rdata  = rd_word;
          next_st.rresp  = is_mapped(s_axi_araddr) && s_axi_araddr != ext_irq_pkg::off_ack ?
                           ext_irq_pkg::resp_okay : ext_irq_pkg::resp_slverr;
        end
      end
      ext_irq_pkg::bus_resp:
      begin
        if (s_axi_rready)
        begin
          next_st.rst_st = ext_irq_pkg::bus_idle;
        end
      end
      default: next_st.rst_st = ext_irq_pkg::bus_idle;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // state register
  always_ff @(posedge i_sys_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      st <= '0;
    end
    else
    begin
      st <= next_st;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs
  always_comb
  begin
    o_ext_req     = {4{st.gie}} & st.mask & (st.flags | low_lvl);
    o_grp_req     = {4{st.gie}} & st.genab & st.gflag;
    // clockless wake: raw low level or raw difference from last sample
    o_wake        = |(low_lvl & st.mask) |
                    |((i_change_inputs ^ st.chg_old) & chg_en);
    s_axi_awready = wr_go;
    s_axi_wready  = wr_go;
    s_axi_bvalid  = (st.wst == ext_irq_pkg::bus_resp);
    s_axi_bresp   = st.bresp;
    s_axi_arready = (st.rst_st == ext_irq_pkg::bus_idle);
    s_axi_rvalid  = (st.rst_st == ext_irq_pkg::bus_resp);
    s_axi_rdata   = st.rdata;
    s_axi_rresp   = st.rresp;
  end

  ////////////////////////////////////////////////////////////////////////////
  // checks
  req_gate_a: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    (o_ext_req != 4'h0) |-> (st.gie && (o_ext_req & ~st.mask) == 4'h0))
    else $error("dedicated request without enables");
  fall_flag_a: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    (st.sense[5:4] == 2'h2 && st.ext_s2[2] && !st.ext_s1[2] && $stable(st.sense))
    |=> ##1 st.flags[2])
    else $error("falling edge missed pin 2");
  rise_flag_a: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    (st.sense[7:6] == 2'h3 && !st.ext_s2[3] && st.ext_s1[3] && $stable(st.sense))
    |=> ##1 st.flags[3])
    else $error("rising edge missed pin 3");
  low_level_a: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    (st.sense[1:0] == 2'h0 && st.gie && st.mask[0] && !i_ext_irq_pins[0])
    |-> o_ext_req[0])
    else $error("low level not requested");
  low_clear_a: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    $past(st.sense[1:0] == 2'h0) |-> !st.flags[0])
    else $error("flag set in level mode");
  upper_zero_a: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    s_axi_rvalid && st.rresp == 2'h0 |-> s_axi_rdata[31:8] == 24'h0)
    else $error("upper read bits not zero");
  grp_flag_a: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    (chg_diff[25] && chg_en[25]) |=> st.gflag[3])
    else $error("group 3 change missed");
  wone_clear_a: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    (wclr_grp[2] && !grp_hit[2]) |=> !st.gflag[2])
    else $error("write one did not clear");
  grp_vec_a: assert property (@(posedge i_sys_clk) disable iff (!i_rst_n)
    o_grp_req[2] |-> (st.genab[2] && st.gie && st.gflag[2]))
    else $error("group request without enables");

endmodule // ext_pin_irq

/* ext_pin_source.sv */
// Purpose: board-side source that drives the dedicated and pin-change inputs
// Assumes: levels are commanded by the bench; one system clock
// Notes:   slow mode adds one clock of lag, as a long board trace would
`timescale 1ns/100ps

module ext_pin_source (
  input  wire logic        i_sys_clk,      // system clock
  input  wire logic        i_rst_n,        // async reset, active low
  input  wire logic [3:0]  i_ext_level,    // commanded dedicated pin levels
  input  wire logic [26:0] i_chg_level,    // commanded change input levels
  input  wire logic        i_slow,         // answer one clock later
  output logic      [3:0]  o_ext_pins,     // dedicated pins toward the block
  output logic      [26:0] o_change_inputs // change inputs toward the block
);
  logic [30:0] lag_q; // delay stage for slow mode

  //////////////////////////////////////////////////////////////////////////////
  // pins are always driven and hold their level until commanded again
  always_ff @(posedge i_sys_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      lag_q <= {4'hf, 27'h0000000};
      {o_ext_pins, o_change_inputs} <= {4'hf, 27'h0000000};
    end
    else
    begin
      lag_q <= {i_ext_level, i_chg_level};
      {o_ext_pins, o_change_inputs} <= i_slow ? lag_q : {i_ext_level, i_chg_level};
    end
  end
endmodule // ext_pin_source

/* external_pin_change_irq_tb_top.sv */
// Purpose: self-checking bench for the external pin interrupt block
// Assumes: axi4-lite master in the bench, board source model on the pins
// Notes:   expected values follow the sense, mask and group settings
`timescale 1ns/100ps

module external_pin_change_irq_tb_top;
  logic        i_sys_clk = 1'b0;         // 50 mhz clock
  logic        i_rst_n = 1'b0;           // async reset, active low
  logic [3:0]  ext_lvl = 4'hf;           // commanded dedicated levels
  logic [26:0] chg_lvl = 27'h0000000;    // commanded change levels
  logic        slow = 1'b0;              // partner lag select
  logic [3:0]  ext_ack = 4'h0;           // dedicated vector entry pulses
  logic [3:0]  grp_ack = 4'h0;           // group vector entry pulses
  logic [5:0]  s_axi_awaddr = 6'h00;     // bus request fields
  logic [5:0]  s_axi_araddr = 6'h00;
  logic [31:0] s_axi_wdata = 32'h00000000;
  logic [3:0]  s_axi_wstrb = 4'hf;
  logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0]  s_axi_bresp, s_axi_rresp; // responses
  logic [31:0] s_axi_rdata;              // read data
  logic [3:0]  o_ext_req, o_grp_req, pins; // requests and driven pins
  logic        o_wake;                   // wake level
  logic [26:0] chg;                      // driven change inputs
  int          mismatches = 0, n_compared = 0, cycles = 0;

  ext_pin_source partner (.i_sys_clk(i_sys_clk), .i_rst_n(i_rst_n), .i_ext_level(ext_lvl),
    .i_chg_level(chg_lvl), .i_slow(slow), .o_ext_pins(pins), .o_change_inputs(chg));
  ext_pin_irq DUT (.i_sys_clk(i_sys_clk), .i_rst_n(i_rst_n), .i_ext_irq_pins(pins), .i_change_inputs(chg),
    .i_ext_vec_ack(ext_ack), .i_grp_vec_ack(grp_ack), .o_ext_req(o_ext_req), .o_grp_req(o_grp_req),
    .o_wake(o_wake), .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready));

  //////////////////////////////////////////////////////////////////////////////
  // clock and hang guard
  initial
  begin
    forever #10 i_sys_clk = ~i_sys_clk;
  end
  always @(posedge i_sys_clk)
  begin
    cycles <= cycles + 1;
    if (cycles == 20000)
    begin
      mismatches = mismatches + 1;
      wrap_up();
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // shared tasks: compare, bus cycles, waits
  task automatic wrap_up();
    begin
      $display("compared %0d mismatches %0d", n_compared, mismatches);
      if (mismatches == 0 && n_compared > 0)
        $display("TEST PASSED");
      else
        $display("TEST FAILED");
      $finish;
    end
  endtask
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    begin
      n_compared++;
      if (got !== exp)
      begin
        $display("[FAIL] %s expected %h seen %h", what, exp, got);
        mismatches++;
      end
    end
  endtask
  task automatic wait_cyc(input int n);
    begin
      repeat (n) @(posedge i_sys_clk);
    end
  endtask
  // ready is sampled mid-cycle, where it equals its value at the next edge
  task automatic wr(input logic [5:0] a, input logic [7:0] d);
    logic aw_hs, w_hs, b_hs;
    logic [1:0] r;
    begin
      @(posedge i_sys_clk);
      s_axi_awaddr <= a;
      s_axi_wdata <= {24'h000000, d};
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      do
      begin
        @(negedge i_sys_clk);
        aw_hs = s_axi_awvalid & s_axi_awready;
        w_hs = s_axi_wvalid & s_axi_wready;
        b_hs = s_axi_bvalid;
        r = s_axi_bresp;
        @(posedge i_sys_clk);
        if (aw_hs) s_axi_awvalid <= 1'b0;
        if (w_hs) s_axi_wvalid <= 1'b0;
      end while (!b_hs);
      s_axi_bready <= 1'b0;
      chk("bresp", {30'h0, ext_irq_pkg::resp_okay}, {30'h0, r});
    end
  endtask
  task automatic rd(input logic [5:0] a, output logic [31:0] d, output logic [1:0] r);
    logic ar_hs, r_hs;
    begin
      @(posedge i_sys_clk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do
      begin
        @(negedge i_sys_clk);
        ar_hs = s_axi_arvalid & s_axi_arready;
        r_hs = s_axi_rvalid;
        d = s_axi_rdata;
        r = s_axi_rresp;
        @(posedge i_sys_clk);
        if (ar_hs) s_axi_arvalid <= 1'b0;
      end while (!r_hs);
      s_axi_rready <= 1'b0;
    end
  endtask
  task automatic rd_chk(input logic [5:0] a, input logic [7:0] exp, input string what);
    logic [31:0] d;
    logic [1:0] r;
    begin
      rd(a, d, r);
      chk(what, {24'h000000, exp}, d);
      chk("rresp", {30'h0, ext_irq_pkg::resp_okay}, {30'h0, r});
    end
  endtask
  // outputs settle after the edge before they are looked at
  task automatic req_chk(input string what, input logic [3:0] e, input logic [3:0] g);
    begin
      #1;
      chk(what, {28'h0, e}, {28'h0, o_ext_req});
      chk(what, {28'h0, g}, {28'h0, o_grp_req});
    end
  endtask

  //////////////////////////////////////////////////////////////////////////////
  // scenarios
  task automatic test_regs();
    logic [5:0] offs [7];
    logic [31:0] d;
    logic [1:0] r;
    begin
      offs = '{ext_irq_pkg::off_sense, ext_irq_pkg::off_mask, ext_irq_pkg::off_flags, ext_irq_pkg::off_genab,
               ext_irq_pkg::off_gflag, ext_irq_pkg::off_msk3, ext_irq_pkg::off_msk2};
      for (int i = 0; i < 7; i++) rd_chk(offs[i], ext_irq_pkg::rst_byte, "reset_value");
      rd(6'h2c, d, r);
      chk("unmapped_resp", {30'h0, ext_irq_pkg::resp_slverr}, {30'h0, r});
      chk("unmapped_data", 32'h00000000, d);
      rd(ext_irq_pkg::off_ack, d, r);
      chk("ack_read_resp", {30'h0, ext_irq_pkg::resp_slverr}, {30'h0, r});
      for (int i = 1; i < 7; i = i + 2) wr(offs[i], 8'hff);
      rd_chk(ext_irq_pkg::off_mask, 8'h0f, "mask_upper");
      rd_chk(ext_irq_pkg::off_genab, 8'h0f, "genab_upper");
      rd_chk(ext_irq_pkg::off_msk3, {5'h00, ext_irq_pkg::msk3_used}, "msk3_upper");
      for (int i = 1; i < 7; i = i + 2) wr(offs[i], 8'h00);
      $display("test_regs done");
    end
  endtask
  task automatic test_edges();
    logic [7:0] b;
    begin
      wr(ext_irq_pkg::off_ctrl, 8'h01);
      for (int m = 1; m < 4; m++)
      begin
        b = 8'h01 << m;
        wr(ext_irq_pkg::off_mask, 8'h00);
        wr(ext_irq_pkg::off_sense, 8'(m << (2 * m)));
        wr(ext_irq_pkg::off_flags, 8'h0f);
        wr(ext_irq_pkg::off_mask, b);
        ext_lvl[m] <= 1'b0;
        wait_cyc(6);
        rd_chk(ext_irq_pkg::off_flags, (m != 3) ? b : 8'h00, "fall_flag");
        req_chk("edge_req", (m != 3) ? b[3:0] : 4'h0, 4'h0);
        wr(ext_irq_pkg::off_flags, b);
        rd_chk(ext_irq_pkg::off_flags, 8'h00, "flag_w1c");
        ext_lvl[m] <= 1'b1;
        wait_cyc(6);
        rd_chk(ext_irq_pkg::off_flags, (m != 2) ? b : 8'h00, "rise_flag");
        wr(ext_irq_pkg::off_flags, 8'h00);
        rd_chk(ext_irq_pkg::off_flags, (m != 2) ? b : 8'h00, "flag_w0");
        if (m == 3)
          wr(ext_irq_pkg::off_ack, b);
        else
        begin
          ext_ack <= b[3:0];
          @(posedge i_sys_clk);
          ext_ack <= 4'h0;
        end
        rd_chk(ext_irq_pkg::off_flags, 8'h00, "flag_ack");
      end
      wr(ext_irq_pkg::off_mask, 8'h00);
      wr(ext_irq_pkg::off_sense, 8'h00);
      $display("test_edges done");
    end
  endtask
  task automatic test_low();
    begin
      wr(ext_irq_pkg::off_mask, 8'h01);
      ext_lvl[0] <= 1'b0;
      wait_cyc(2);
      repeat (4)
      begin
        @(posedge i_sys_clk);
        req_chk("low_req", 4'h1, 4'h0);
      end
      chk("low_wake", 32'h00000001, {31'h0, o_wake});
      rd_chk(ext_irq_pkg::off_flags, 8'h00, "low_flag");
      wr(ext_irq_pkg::off_ctrl, 8'h00);
      req_chk("gie_off", 4'h0, 4'h0);
      wr(ext_irq_pkg::off_ctrl, 8'h01);
      wr(ext_irq_pkg::off_mask, 8'h00);
      ext_lvl[0] <= 1'b1;
      req_chk("mask_off", 4'h0, 4'h0);
      $display("test_low done");
    end
  endtask
  task automatic test_groups();
    logic [5:0] moff [4];
    logic seen;
    int p;
    begin
      moff = '{ext_irq_pkg::off_msk0, ext_irq_pkg::off_msk1, ext_irq_pkg::off_msk2, ext_irq_pkg::off_msk3};
      @(posedge i_sys_clk);
      slow <= 1'b1;
      for (int g = 0; g < 4; g++)
      begin
        p = 8 * g + 1;
        wr(moff[g], 8'h02);
        wr(ext_irq_pkg::off_genab, 8'(1 << g));
        chg_lvl[p + 1] <= ~chg_lvl[p + 1];
        wait_cyc(8);
        rd_chk(ext_irq_pkg::off_gflag, 8'h00, "masked_pin");
        chg_lvl[p] <= ~chg_lvl[p];
        seen = 1'b0;
        repeat (6)
        begin
          @(negedge i_sys_clk);
          seen = seen | (o_wake === 1'b1);
        end
        chk("wake", 32'h00000001, {31'h0, seen});
        wait_cyc(4);
        rd_chk(ext_irq_pkg::off_gflag, 8'(1 << g), "group_flag");
        req_chk("group_req", 4'h0, 4'(1 << g));
        if (g == 2)
          wr(ext_irq_pkg::off_gflag, 8'h04);
        else if (g == 3)
          wr(ext_irq_pkg::off_ack, 8'h80);
        else
        begin
          @(posedge i_sys_clk);
          grp_ack <= 4'(1 << g);
          @(posedge i_sys_clk);
          grp_ack <= 4'h0;
        end
        rd_chk(ext_irq_pkg::off_gflag, 8'h00, "group_ack");
        wr(moff[g], 8'h00);
      end
      wr(ext_irq_pkg::off_genab, 8'h00);
      slow <= 1'b0;
      $display("test_groups done");
    end
  endtask

  //////////////////////////////////////////////////////////////////////////////
  // main sequence
  initial
  begin
    repeat (20) @(posedge i_sys_clk);
    i_rst_n <= 1'b1;
    @(posedge i_sys_clk);
    test_regs();
    test_edges();
    test_low();
    test_groups();
    wrap_up();
  end
endmodule // external_pin_change_irq_tb_top
